// [src/pipe_consts.svh]
// Constants shared by the branch and jump cache pipeline control files.
`ifndef PIPE_CONSTS_SVH
`define PIPE_CONSTS_SVH
`define INSTR_W 32
`define IP_W 16
`define CSP_W 8
`define ADDR_W 24
`define DATA_W 16
`define GPR_SEL_W 4
`define DPP_N 4
`define DPP_SEL_W 2
`define DPP_W 10
`define PAGE_OFS_W 14
`define IP_STEP 16'h0004
`define IP_RESET 16'h0000
`define CSP_RESET 8'h00
`define CP_RESET 16'h0000
`define DPP_RESET 10'h000
`define WORD_RESET 16'h0000
`define INSTR_INJECT 32'h00000000
`define INSTR_RESET 32'h00000000
`define ADDR_RESET 24'h000000
`endif

// [src/pipe_pkg.sv]
// Types shared by the branch and jump cache pipeline control files.
`include "pipe_consts.svh"
package pipe_pkg;
    typedef logic [`INSTR_W-1:0] instr_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`DPP_W-1:0] page_t;
    typedef enum logic {ST_RUN, ST_FILL} fetch_state_t;
endpackage

// [src/jump_cache.sv]
// Single-entry jump target cache with registered read data.
`include "pipe_consts.svh"
module jump_cache (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire pipe_pkg::addr_t wr_tag_i,
    input wire pipe_pkg::instr_t wr_data_i,
    input wire logic inval_i,
    input wire pipe_pkg::addr_t look_tag_i,
    output logic hit_o,
    output pipe_pkg::instr_t data_o
);
    logic valid_q, valid_d;
    pipe_pkg::addr_t tag_q, tag_d;
    pipe_pkg::instr_t data_q, data_d;

    // Invalidation beats a concurrent fill, so a stale target never survives a segment change.
    always_comb
    begin
        valid_d = valid_q;
        tag_d = tag_q;
        data_d = data_q;
        if (inval_i)
        begin
            valid_d = 1'b0;
        end
        else if (wr_en_i)
        begin
            valid_d = 1'b1;
            tag_d = wr_tag_i;
            data_d = wr_data_i;
        end
    end

    // Entry storage.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            valid_q <= 1'b0;
            tag_q <= `ADDR_RESET;
            data_q <= `INSTR_RESET;
        end
        else
        begin
            valid_q <= valid_d;
            tag_q <= tag_d;
            data_q <= data_d;
        end
    end

    // The hit compares against the stored tag; data leave straight from the register.
    assign hit_o = valid_q && (tag_q == look_tag_i);
    assign data_o = data_q;
endmodule

// [src/operand_forward.sv]
// Operand bypass from execute and write back toward the decode-stage read.
`include "pipe_consts.svh"
module operand_forward (
    input wire pipe_pkg::word_t rd_addr_i,
    input wire pipe_pkg::word_t rf_data_i,
    input wire logic ex_wr_en_i,
    input wire pipe_pkg::word_t ex_wr_addr_i,
    input wire pipe_pkg::word_t ex_wr_data_i,
    input wire logic wb_wr_en_i,
    input wire pipe_pkg::word_t wb_wr_addr_i,
    input wire pipe_pkg::word_t wb_wr_data_i,
    output pipe_pkg::word_t data_o
);
    // The younger execute result has priority, since it is the newer value of the location.
    always_comb
    begin
        data_o = rf_data_i;
        if (ex_wr_en_i && (ex_wr_addr_i == rd_addr_i))
        begin
            data_o = ex_wr_data_i;
        end
        else if (wb_wr_en_i && (wb_wr_addr_i == rd_addr_i))
        begin
            data_o = wb_wr_data_i;
        end
    end
endmodule

// [src/branch_jump_cache_pipeline.sv]
// Four-stage pipeline control with branch injection, jump cache and operand forwarding.
`include "pipe_consts.svh"
module branch_jump_cache_pipeline (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire pipe_pkg::instr_t fetch_instr_i,
    input wire logic dec_branch_i,
    input wire logic dec_eligible_i,
    input wire logic dec_taken_i,
    input wire pipe_pkg::addr_t dec_target_i,
    input wire logic dec_csp_change_i,
    input wire logic std_irq_i,
    input wire logic [`GPR_SEL_W-1:0] dec_gpr_sel_i,
    input wire logic [`DPP_SEL_W-1:0] dec_dpp_sel_i,
    input wire logic [`PAGE_OFS_W-1:0] dec_page_ofs_i,
    input wire pipe_pkg::word_t dec_rd_addr_i,
    input wire pipe_pkg::word_t rf_rd_data_i,
    input wire logic ex_wr_en_i,
    input wire pipe_pkg::word_t ex_wr_addr_i,
    input wire pipe_pkg::word_t ex_wr_data_i,
    input wire logic wb_wr_en_i,
    input wire pipe_pkg::word_t wb_wr_addr_i,
    input wire pipe_pkg::word_t wb_wr_data_i,
    input wire logic cp_wr_en_i,
    input wire pipe_pkg::word_t cp_wr_data_i,
    input wire logic dpp_wr_en_i,
    input wire logic [`DPP_SEL_W-1:0] dpp_wr_sel_i,
    input wire pipe_pkg::page_t dpp_wr_data_i,
    output logic fetch_req_o,
    output pipe_pkg::addr_t fetch_addr_o,
    output logic dec_valid_o,
    output logic dec_inject_o,
    output pipe_pkg::instr_t dec_instr_o,
    output pipe_pkg::addr_t dec_pc_o,
    output logic ex_valid_o,
    output logic ex_inject_o,
    output pipe_pkg::instr_t ex_instr_o,
    output pipe_pkg::word_t ex_operand_o,
    output pipe_pkg::word_t ex_gpr_addr_o,
    output pipe_pkg::addr_t ex_data_addr_o,
    output logic wb_valid_o,
    output logic wb_inject_o,
    output pipe_pkg::instr_t wb_instr_o,
    output pipe_pkg::word_t context_pointer_o,
    output logic cache_hit_o
);
    logic rst_meta_q, rst_sync_q;
    logic fetch_req_q, fetch_req_d;
    logic [`CSP_W-1:0] code_segment_pointer_q, code_segment_pointer_d;
    logic [`IP_W-1:0] ip_q, ip_d;
    pipe_pkg::fetch_state_t state_q, state_d;
    pipe_pkg::addr_t fill_tag_q, fill_tag_d;
    logic dec_valid_q, dec_valid_d, dec_inject_q, dec_inject_d;
    pipe_pkg::instr_t dec_instr_q, dec_instr_d;
    pipe_pkg::addr_t dec_pc_q, dec_pc_d;
    logic ex_valid_q, ex_valid_d, ex_inject_q, ex_inject_d;
    pipe_pkg::instr_t ex_instr_q, ex_instr_d;
    pipe_pkg::word_t ex_operand_q, ex_operand_d, ex_gpr_addr_q, ex_gpr_addr_d;
    pipe_pkg::addr_t ex_data_addr_q, ex_data_addr_d;
    logic wb_valid_q, wb_valid_d, wb_inject_q, wb_inject_d;
    pipe_pkg::instr_t wb_instr_q, wb_instr_d;
    logic cache_hit_q, cache_hit_d;
    pipe_pkg::word_t context_pointer_q, context_pointer_d;
    pipe_pkg::page_t data_page_pointer_q [`DPP_N];
    pipe_pkg::page_t data_page_pointer_d [`DPP_N];
    logic dec_live, br_taken, take_hit, take_miss, inval, c_hit, c_wr;
    pipe_pkg::instr_t c_data;
    pipe_pkg::word_t fwd_data;

    // Reset is released through two flops so every stage leaves reset on the same edge.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Decode-stage branch resolution; injected slots never act as branches.
    assign dec_live = dec_valid_q && !dec_inject_q;
    assign br_taken = dec_live && dec_branch_i && dec_taken_i;
    assign take_hit = br_taken && dec_eligible_i && c_hit && !std_irq_i;
    assign take_miss = br_taken && !take_hit;
    assign inval = (dec_live && dec_csp_change_i) || std_irq_i;
    assign c_wr = (state_q == pipe_pkg::ST_FILL);

    jump_cache u_cache (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_sync_q),
        .wr_en_i(c_wr),
        .wr_tag_i(fill_tag_q),
        .wr_data_i(fetch_instr_i),
        .inval_i(inval),
        .look_tag_i(dec_pc_q),
        .hit_o(c_hit),
        .data_o(c_data)
    );

    operand_forward u_fwd (
        .rd_addr_i(dec_rd_addr_i),
        .rf_data_i(rf_rd_data_i),
        .ex_wr_en_i(ex_wr_en_i),
        .ex_wr_addr_i(ex_wr_addr_i),
        .ex_wr_data_i(ex_wr_data_i),
        .wb_wr_en_i(wb_wr_en_i),
        .wb_wr_addr_i(wb_wr_addr_i),
        .wb_wr_data_i(wb_wr_data_i),
        .data_o(fwd_data)
    );

    // Next values of fetch pointer, stage registers and fill state.
    always_comb
    begin
        fetch_req_d = 1'b1;
        ip_d = ip_q + `IP_STEP;
        code_segment_pointer_d = code_segment_pointer_q;
        state_d = pipe_pkg::ST_RUN;
        fill_tag_d = fill_tag_q;
        dec_valid_d = fetch_req_q;
        dec_inject_d = 1'b0;
        dec_instr_d = fetch_instr_i;
        dec_pc_d = fetch_addr_o;
        cache_hit_d = take_hit;
        if (take_miss)
        begin
            {code_segment_pointer_d, ip_d} = dec_target_i;
            dec_instr_d = `INSTR_INJECT;
            dec_inject_d = 1'b1;
            dec_pc_d = dec_target_i;
            if (dec_eligible_i && !inval)
            begin
                state_d = pipe_pkg::ST_FILL;
                fill_tag_d = dec_pc_q;
            end
        end
        else if (take_hit)
        begin
            code_segment_pointer_d = dec_target_i[`ADDR_W-1:`IP_W];
            ip_d = dec_target_i[`IP_W-1:0] + `IP_STEP;
            dec_instr_d = c_data;
            dec_pc_d = dec_target_i;
        end
        ex_valid_d = dec_valid_q;
        ex_inject_d = dec_inject_q;
        ex_instr_d = dec_instr_q;
        ex_operand_d = fwd_data;
        // The stored pointer, not its next value, is used: an update in execute lands one slot late.
        ex_gpr_addr_d = context_pointer_q + {{(`DATA_W-`GPR_SEL_W-1){1'b0}}, dec_gpr_sel_i, 1'b0};
        ex_data_addr_d = {data_page_pointer_q[dec_dpp_sel_i], dec_page_ofs_i};
        wb_valid_d = ex_valid_q;
        wb_inject_d = ex_inject_q;
        wb_instr_d = ex_instr_q;
    end

    // Stage registers.
    always_ff @(posedge clk_sys_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            fetch_req_q <= 1'b0;
            ip_q <= `IP_RESET;
            code_segment_pointer_q <= `CSP_RESET;
            state_q <= pipe_pkg::ST_RUN;
            fill_tag_q <= `ADDR_RESET;
            dec_valid_q <= 1'b0;
            dec_inject_q <= 1'b0;
            dec_instr_q <= `INSTR_RESET;
            dec_pc_q <= `ADDR_RESET;
            ex_valid_q <= 1'b0;
            ex_inject_q <= 1'b0;
            ex_instr_q <= `INSTR_RESET;
            ex_operand_q <= `WORD_RESET;
            ex_gpr_addr_q <= `WORD_RESET;
            ex_data_addr_q <= `ADDR_RESET;
            wb_valid_q <= 1'b0;
            wb_inject_q <= 1'b0;
            wb_instr_q <= `INSTR_RESET;
            cache_hit_q <= 1'b0;
        end
        else
        begin
            fetch_req_q <= fetch_req_d;
            ip_q <= ip_d;
            code_segment_pointer_q <= code_segment_pointer_d;
            state_q <= state_d;
            fill_tag_q <= fill_tag_d;
            dec_valid_q <= dec_valid_d;
            dec_inject_q <= dec_inject_d;
            dec_instr_q <= dec_instr_d;
            dec_pc_q <= dec_pc_d;
            ex_valid_q <= ex_valid_d;
            ex_inject_q <= ex_inject_d;
            ex_instr_q <= ex_instr_d;
            ex_operand_q <= ex_operand_d;
            ex_gpr_addr_q <= ex_gpr_addr_d;
            ex_data_addr_q <= ex_data_addr_d;
            wb_valid_q <= wb_valid_d;
            wb_inject_q <= wb_inject_d;
            wb_instr_q <= wb_instr_d;
            cache_hit_q <= cache_hit_d;
        end
    end

    // Context pointer, written from the execute stage.
    always_comb
    begin
        context_pointer_d = cp_wr_en_i ? cp_wr_data_i : context_pointer_q;
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            context_pointer_q <= `CP_RESET;
        end
        else
        begin
            context_pointer_q <= context_pointer_d;
        end
    end

    // Data page pointers, one register per page slot.
    for (genvar g = 0; g < `DPP_N; g++)
    begin : g_dpp
        always_comb
        begin
            data_page_pointer_d[g] = (dpp_wr_en_i && dpp_wr_sel_i == `DPP_SEL_W'(g)) ? dpp_wr_data_i
                : data_page_pointer_q[g];
        end

        always_ff @(posedge clk_sys_i or negedge rst_sync_q)
        begin
            if (!rst_sync_q)
            begin
                data_page_pointer_q[g] <= `DPP_RESET;
            end
            else
            begin
                data_page_pointer_q[g] <= data_page_pointer_d[g];
            end
        end
    end

    // Every output leaves straight from a flop.
    assign fetch_req_o = fetch_req_q;
    assign fetch_addr_o = {code_segment_pointer_q, ip_q};
    assign dec_valid_o = dec_valid_q;
    assign dec_inject_o = dec_inject_q;
    assign dec_instr_o = dec_instr_q;
    assign dec_pc_o = dec_pc_q;
    assign ex_valid_o = ex_valid_q;
    assign ex_inject_o = ex_inject_q;
    assign ex_instr_o = ex_instr_q;
    assign ex_operand_o = ex_operand_q;
    assign ex_gpr_addr_o = ex_gpr_addr_q;
    assign ex_data_addr_o = ex_data_addr_q;
    assign wb_valid_o = wb_valid_q;
    assign wb_inject_o = wb_inject_q;
    assign wb_instr_o = wb_instr_q;
    assign context_pointer_o = context_pointer_q;
    assign cache_hit_o = cache_hit_q;

    // Checks on branch timing, cache use, forwarding and pointer updates.
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_sync_q);

    property p_miss_injects;
        take_miss |=> dec_inject_q && dec_valid_q ##1 !dec_inject_q && dec_pc_q == $past(fetch_addr_o);
    endproperty
    a_miss_injects: assert property (p_miss_injects) else $error("Taken miss did not inject one slot.");
    property p_fall_through;
        (dec_live && dec_branch_i && !dec_taken_i) |=> !dec_inject_q && dec_pc_q == $past(fetch_addr_o);
    endproperty
    a_fall_through: assert property (p_fall_through) else $error("Untaken branch delayed successor.");
    // The stored entry is checked itself, since by then the lookup address has moved on to the target.
    property p_fill;
        (take_miss && dec_eligible_i && !inval) ##1 !inval |=> u_cache.valid_q && u_cache.tag_q == $past(dec_pc_q, 2)
            && c_data == $past(fetch_instr_i);
    endproperty
    a_fill: assert property (p_fill) else $error("Cache not loaded after first taken jump.");
    property p_only_eligible;
        c_wr |-> $past(take_miss && dec_eligible_i);
    endproperty
    a_only_eligible: assert property (p_only_eligible) else $error("Cache written by a non-cacheable branch.");
    property p_hit_direct;
        take_hit |=> !dec_inject_q && dec_instr_q == $past(c_data) && cache_hit_q;
    endproperty
    a_hit_direct: assert property (p_hit_direct) else $error("Cache hit did not feed decode directly.");
    property p_inval;
        inval |=> !c_hit;
    endproperty
    a_inval: assert property (p_inval) else $error("Cache still hits after invalidation.");
    property p_forward;
        (ex_wr_en_i && ex_wr_addr_i == dec_rd_addr_i) |=> ex_operand_q == $past(ex_wr_data_i);
    endproperty
    a_forward: assert property (p_forward) else $error("Execute result not forwarded.");
    property p_stages;
        dec_valid_q |=> ex_valid_q && ex_instr_q == $past(dec_instr_q) ##1 wb_instr_q == $past(dec_instr_q, 2);
    endproperty
    a_stages: assert property (p_stages) else $error("Instruction lost between stages.");
    property p_target_load;
        take_miss |=> fetch_addr_o == $past(dec_target_i);
    endproperty
    a_target_load: assert property (p_target_load) else $error("Pointers not loaded with target.");
    property p_cp_update;
        cp_wr_en_i |=> context_pointer_q == $past(cp_wr_data_i);
    endproperty
    a_cp_update: assert property (p_cp_update) else $error("Context pointer not written.");

    c_hit_seen: cover property (take_hit);
    c_miss_fill: cover property (take_miss && dec_eligible_i ##2 u_cache.valid_q);
    c_untaken: cover property (dec_live && dec_branch_i && !dec_taken_i);
    c_inval_hit: cover property (c_hit && inval);
endmodule

// [testbench/prog_mem_model.sv]
// Behavioural program memory answering the fetch path of the pipeline control.
`include "pipe_consts.svh"
module prog_mem_model (
    input wire logic fetch_req_i,
    input wire pipe_pkg::addr_t fetch_addr_i,
    output pipe_pkg::instr_t instr_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Each word carries its own address, so a wrong fetch shows up as a wrong word.
    // When no fetch is requested the bus shows the inverse pattern, so a stale capture cannot pass.
    always_comb
    begin
        if (fetch_req_i === 1'b1)
            instr_o = {8'hC3, fetch_addr_i};
        else
            instr_o = ~{8'hC3, fetch_addr_i};
    end
endmodule

// [testbench/branch_jump_cache_pipeline_tb.sv]
// Self-checking testbench for the branch, jump cache and forwarding pipeline control.
`include "pipe_consts.svh"
module branch_jump_cache_pipeline_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    pipe_pkg::instr_t fetch_instr_i;
    logic dec_branch_i = 1'b0;
    logic dec_eligible_i = 1'b0;
    logic dec_taken_i = 1'b0;
    pipe_pkg::addr_t dec_target_i = '0;
    logic dec_csp_change_i = 1'b0;
    logic std_irq_i = 1'b0;
    logic [`GPR_SEL_W-1:0] dec_gpr_sel_i = '0;
    logic [`DPP_SEL_W-1:0] dec_dpp_sel_i = '0;
    logic [`PAGE_OFS_W-1:0] dec_page_ofs_i = '0;
    pipe_pkg::word_t dec_rd_addr_i = 16'h0012;
    pipe_pkg::word_t rf_rd_data_i = 16'h1111;
    logic ex_wr_en_i = 1'b0;
    pipe_pkg::word_t ex_wr_addr_i = 16'h0012;
    pipe_pkg::word_t ex_wr_data_i = 16'h2222;
    logic wb_wr_en_i = 1'b0;
    pipe_pkg::word_t wb_wr_addr_i = 16'h0012;
    pipe_pkg::word_t wb_wr_data_i = 16'h3333;
    logic cp_wr_en_i = 1'b0;
    pipe_pkg::word_t cp_wr_data_i = '0;
    logic dpp_wr_en_i = 1'b0;
    logic [`DPP_SEL_W-1:0] dpp_wr_sel_i = '0;
    pipe_pkg::page_t dpp_wr_data_i = '0;
    logic fetch_req_o;
    pipe_pkg::addr_t fetch_addr_o;
    logic dec_valid_o;
    logic dec_inject_o;
    pipe_pkg::instr_t dec_instr_o;
    pipe_pkg::addr_t dec_pc_o;
    logic ex_valid_o;
    logic ex_inject_o;
    pipe_pkg::instr_t ex_instr_o;
    pipe_pkg::word_t ex_operand_o;
    pipe_pkg::word_t ex_gpr_addr_o;
    pipe_pkg::addr_t ex_data_addr_o;
    logic wb_valid_o;
    logic wb_inject_o;
    pipe_pkg::instr_t wb_instr_o;
    pipe_pkg::word_t context_pointer_o;
    logic cache_hit_o;
    int n_fail = 0;
    int checks_done = 0;

    branch_jump_cache_pipeline u_branch_jump_cache_pipeline (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .fetch_instr_i(fetch_instr_i), .dec_branch_i(dec_branch_i), .dec_eligible_i(dec_eligible_i),
        .dec_taken_i(dec_taken_i), .dec_target_i(dec_target_i), .dec_csp_change_i(dec_csp_change_i),
        .std_irq_i(std_irq_i), .dec_gpr_sel_i(dec_gpr_sel_i), .dec_dpp_sel_i(dec_dpp_sel_i),
        .dec_page_ofs_i(dec_page_ofs_i), .dec_rd_addr_i(dec_rd_addr_i), .rf_rd_data_i(rf_rd_data_i),
        .ex_wr_en_i(ex_wr_en_i), .ex_wr_addr_i(ex_wr_addr_i), .ex_wr_data_i(ex_wr_data_i),
        .wb_wr_en_i(wb_wr_en_i), .wb_wr_addr_i(wb_wr_addr_i), .wb_wr_data_i(wb_wr_data_i),
        .cp_wr_en_i(cp_wr_en_i), .cp_wr_data_i(cp_wr_data_i), .dpp_wr_en_i(dpp_wr_en_i),
        .dpp_wr_sel_i(dpp_wr_sel_i), .dpp_wr_data_i(dpp_wr_data_i), .fetch_req_o(fetch_req_o),
        .fetch_addr_o(fetch_addr_o), .dec_valid_o(dec_valid_o), .dec_inject_o(dec_inject_o),
        .dec_instr_o(dec_instr_o), .dec_pc_o(dec_pc_o), .ex_valid_o(ex_valid_o), .ex_inject_o(ex_inject_o),
        .ex_instr_o(ex_instr_o), .ex_operand_o(ex_operand_o), .ex_gpr_addr_o(ex_gpr_addr_o),
        .ex_data_addr_o(ex_data_addr_o), .wb_valid_o(wb_valid_o), .wb_inject_o(wb_inject_o),
        .wb_instr_o(wb_instr_o), .context_pointer_o(context_pointer_o), .cache_hit_o(cache_hit_o));

    prog_mem_model u_prog_mem_model (.fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o),
        .instr_o(fetch_instr_i));

    // Free-running system clock at 100 MHz.
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Expected program word, kept independent of the memory model's code.
    function automatic logic [31:0] mem_word(input logic [23:0] a);
        return {8'hC3, a};
    endfunction

    // Compares one value; four-state equality so an unknown never matches.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("Checks done: %0d, mismatches: %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Steps falling edges until the given address sits live in decode, with a bound against a lost flow.
    task automatic wait_pc(input logic [23:0] pc);
        int n;
        n = 0;
        while (!(dec_valid_o === 1'b1 && dec_inject_o === 1'b0 && dec_pc_o === pc) && n < 60)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(dec_pc_o, pc, "decode address reached");
    endtask

    // Four instructions fill the stages one behind another after reset.
    // The pointer already steps while the fetch request is still off, so the first decoded word is one step in.
    task automatic seq_fill;
        wait_pc(24'h000004);
        for (int i = 1; i <= 3; i++)
        begin
            @(negedge clk_sys_i);
            chk(dec_instr_o, mem_word(24'(4 * (i + 1))), "decode word");
            chk(ex_instr_o, mem_word(24'(4 * i)), "execute word");
            chk(fetch_addr_o, 24'(4 * (i + 2)), "fetch address");
            chk({fetch_req_o, dec_valid_o, ex_valid_o, wb_valid_o}, (i > 1) ? 4'hF : 4'hE, "stage valids");
            if (i > 1)
                chk(wb_instr_o, mem_word(24'(4 * (i - 1))), "write back word");
        end
    endtask

    // Presents a branch in decode and judges the miss, hit or fall-through that follows.
    task automatic branch_at(input logic [23:0] pc, input logic elig, input logic tkn,
        input logic [23:0] tgt, input logic exp_hit);
        wait_pc(pc);
        dec_branch_i = 1'b1;
        dec_eligible_i = elig;
        dec_taken_i = tkn;
        dec_target_i = tgt;
        @(negedge clk_sys_i);
        dec_branch_i = 1'b0;
        dec_taken_i = 1'b0;
        if (!tkn)
        begin
            chk(dec_pc_o, pc + `IP_STEP, "fall-through address");
            chk(dec_instr_o, mem_word(pc + `IP_STEP), "fall-through word");
            chk(dec_inject_o, 1'b0, "fall-through inject");
        end
        else if (exp_hit)
        begin
            chk(cache_hit_o, 1'b1, "cache hit flag");
            chk(dec_instr_o, mem_word(tgt), "cached word");
            chk(dec_inject_o, 1'b0, "hit inject");
            chk(fetch_addr_o, tgt + `IP_STEP, "hit fetch address");
        end
        else
        begin
            chk(cache_hit_o, 1'b0, "miss flag");
            chk(dec_inject_o, 1'b1, "inject slot");
            chk(dec_instr_o, `INSTR_INJECT, "inject word");
            chk(fetch_addr_o, tgt, "target fetch");
            @(negedge clk_sys_i);
            chk(dec_instr_o, mem_word(tgt), "target word");
            chk(ex_inject_o, 1'b1, "inject in execute");
            @(negedge clk_sys_i);
            chk(wb_inject_o, 1'b1, "inject in write back");
        end
    endtask

    // One bypass case: execute beats write back, write back beats the register file.
    // The enables are left as set; the last case drives both low, so no edge sees them twice in one step.
    task automatic fwd_case(input logic exen, input logic wben, input logic [15:0] exp);
        ex_wr_en_i = exen;
        wb_wr_en_i = wben;
        @(negedge clk_sys_i);
        chk(ex_operand_o, exp, "forwarded operand");
    endtask

    // Pointer writes: the slot right after the write still sees the old value.
    task automatic ptr_updates;
        cp_wr_en_i = 1'b1;
        cp_wr_data_i = 16'h0200;
        dec_gpr_sel_i = 4'h3;
        @(negedge clk_sys_i);
        cp_wr_en_i = 1'b0;
        chk(ex_gpr_addr_o, 16'h0006, "register address old context");
        chk(context_pointer_o, 16'h0200, "context pointer");
        @(negedge clk_sys_i);
        chk(ex_gpr_addr_o, 16'h0206, "register address new context");
        for (int s = 0; s < `DPP_N; s++)
        begin
            dpp_wr_en_i = 1'b1;
            dpp_wr_sel_i = 2'(s);
            dpp_wr_data_i = 10'(s + 1);
            dec_dpp_sel_i = 2'(s);
            dec_page_ofs_i = 14'h0010;
            @(negedge clk_sys_i);
            dpp_wr_en_i = 1'b0;
            chk(ex_data_addr_o, 24'h000010, "data address old page");
            @(negedge clk_sys_i);
            chk(ex_data_addr_o, {10'(s + 1), 14'h0010}, "data address new page");
        end
    endtask

    // Watchdog against a hung flow; the whole run needs under a hundred cycles.
    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        n_fail++;
        finish_test();
    end

    // Main sequence: reset, fill, fall-through, branches, cache fills, hits and invalidations.
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        seq_fill();
        branch_at(24'h000014, 1'b1, 1'b0, 24'h000100, 1'b0);
        branch_at(24'h00001C, 1'b0, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000108, 1'b0, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000108, 1'b0, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b1);
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b1);
        std_irq_i = 1'b1;
        @(negedge clk_sys_i);
        std_irq_i = 1'b0;
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b0);
        wait_pc(24'h000104);
        dec_csp_change_i = 1'b1;
        @(negedge clk_sys_i);
        dec_csp_change_i = 1'b0;
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000104, 1'b1, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b0);
        branch_at(24'h000108, 1'b1, 1'b1, 24'h000100, 1'b1);
        fwd_case(1'b1, 1'b1, 16'h2222);
        fwd_case(1'b0, 1'b1, 16'h3333);
        fwd_case(1'b0, 1'b0, 16'h1111);
        ptr_updates();
        finish_test();
    end
endmodule
